// file: hw/read_data_clock_routing.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] While the route bits disable the pulse output, that pin sits at logic high.
// [RULE2] While the pulse output is enabled, it carries the raw detector pulses.
// [RULE3] With both route bits high the block enters test mode and freezes the amplifier gain.
// [RULE4] In test mode the synchroniser and synthesiser clocks come from external test inputs.
// [RULE5] While the pulse input is enabled, only it feeds the synchroniser and detector data is cut.
// [RULE6] While the pulse output is disabled, detector data goes internally to the synchroniser.
// [RULE7] The synchronised data output is driven straight from the resynchronised data stream.
// [RULE8] The clock output follows the synchroniser clock in read mode, else the synthesiser clock.
// [RULE9] Changing the clock output source never makes a runt pulse or glitch; the code parks only on read-mode changes, not on test-mode changes.
// [RULE10] After reset the reference output is high and idle until its enable bit is set.
// [RULE11] When enabled the reference output runs continuously at the media code clock rate.
// [RULE12] The polarity output follows the hysteresis comparator in the input signal's sense.
// [RULE13] The reference frequency input works with any duty cycle.
// [RULE14] The controller raises read gate for read mode and lowers it otherwise.
// [RULE15] Leaving sleep restores all control bits to defaults, which idles the reference output.
// [RULE16] The route bits are decoded through a table of output, input and test flags.
module read_data_clock_routing
  import route_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Mode pins
  input wire logic read_gate_in,
  input wire logic sleep_n_in,
  // Pulse path
  input wire logic det_pulse_in,
  input wire logic ext_pulse_in,
  output logic raw_pulse_out,
  output logic resync_data_out,
  // Comparator
  input wire logic comparator_in,
  output logic comparator_polarity_out,
  // Clocks from the oscillators and tester
  input wire logic sync_osc_in,
  input wire logic ref_out_a_osc_in,
  input wire logic test_sync_osc_in,
  input wire logic test_ref_out_a_osc_in,
  input wire logic ref_freq_in,
  output logic sync_clk_out,
  output logic ref_out_a,
  // Analog controls
  output logic gain_amp_hold
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] filt_reg;
  logic [NSYNC-1:0] filt_d_reg;
  logic [NSYNC-1:0] raw_in;

  assign raw_in = {sleep_n_in, ref_freq_in, test_ref_out_a_osc_in, test_sync_osc_in,
                   ref_out_a_osc_in, sync_osc_in, comparator_in, det_pulse_in,
                   ext_pulse_in, read_gate_in};

  // A level counts only once the second and third stages agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_reg <= SYNC_RESET;
      s2_reg <= SYNC_RESET;
      s3_reg <= SYNC_RESET;
      filt_reg <= SYNC_RESET;
      filt_d_reg <= SYNC_RESET;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
      filt_d_reg <= filt_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control register and sleep
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_reg;
  logic sleep_active;
  logic [2:0] route_flags;
  logic out_en;
  logic in_en;
  logic test_mode;
  logic ref_en;
  logic read_mode;

  assign sleep_active = !filt_reg[IDX_SLEEP_N];

  // Held at defaults throughout sleep, so wake-up always starts clean
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (sleep_active) begin
      ctrl_reg <= CTRL_RESET; // RULE15
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      ctrl_reg <= reg_wdata;
    end
  end

  assign route_flags = route_decode({ctrl_reg[CTRL_ROUTE_HI_BIT],
                                     ctrl_reg[CTRL_ROUTE_LO_BIT]}); // RULE16
  assign out_en = route_flags[FLAG_OUT];
  assign in_en = route_flags[FLAG_IN];
  assign test_mode = route_flags[FLAG_TEST];
  assign ref_en = ctrl_reg[CTRL_REF_EN_BIT];
  assign read_mode = filt_reg[IDX_RG]; // RULE14

  // ----------------------------------------------------------------
  // Pulse routing
  // ----------------------------------------------------------------
  logic sync_in;
  logic sync_in_d_reg;
  logic sync_src;
  logic ref_out_a_src;

  always_comb begin
    if (in_en) begin
      sync_in = filt_reg[IDX_EXT]; // RULE5
    end else begin
      sync_in = filt_reg[IDX_DET]; // RULE6
    end
  end

  assign sync_src = test_mode ? filt_reg[IDX_TEST_SYNC] : filt_reg[IDX_SYNC_CLK]; // RULE4
  assign ref_out_a_src = test_mode ? filt_reg[IDX_TEST_REF_OUT_A] : filt_reg[IDX_REF_OUT_A_CLK]; // RULE4

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      raw_pulse_out <= 1'b1;
    end else if (out_en) begin
      raw_pulse_out <= filt_reg[IDX_DET]; // RULE2
    end else begin
      raw_pulse_out <= 1'b1; // RULE1
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_amp_hold <= 1'b0;
      comparator_polarity_out <= 1'b0;
    end else begin
      gain_amp_hold <= test_mode; // RULE3
      comparator_polarity_out <= filt_reg[IDX_CMP]; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Clock mux, glitch-free on read-mode source changes only
  // ----------------------------------------------------------------
  mux_state_t mux_state_reg;
  logic cur_sel_reg;
  logic cur_src;
  logic new_src;
  logic sclk_next;
  logic new_src_d;

  assign cur_src = cur_sel_reg ? sync_src : ref_out_a_src;
  assign new_src = read_mode ? sync_src : ref_out_a_src;
  assign new_src_d = read_mode
    ? (test_mode ? filt_d_reg[IDX_TEST_SYNC] : filt_d_reg[IDX_SYNC_CLK])
    : (test_mode ? filt_d_reg[IDX_TEST_REF_OUT_A] : filt_d_reg[IDX_REF_OUT_A_CLK]);

  // Park low on the old source's low phase and rejoin on a falling edge of the new one,
  // so no phase at the pin is shorter than a source phase; a stopped new source keeps it parked
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mux_state_reg <= MUX_RUN;
      cur_sel_reg <= 1'b0;
    end else begin
      case (mux_state_reg)
        MUX_RUN: begin
          if (read_mode != cur_sel_reg && !cur_src) begin
            mux_state_reg <= MUX_PARK; // RULE9
          end
        end
        MUX_PARK: begin
          if (!new_src && new_src_d) begin
            cur_sel_reg <= read_mode; // RULE9
            mux_state_reg <= MUX_RUN;
          end
        end
        default: begin
          mux_state_reg <= MUX_RUN;
        end
      endcase
    end
  end

  always_comb begin
    case (mux_state_reg)
      MUX_RUN: sclk_next = (read_mode != cur_sel_reg && !cur_src) ? 1'b0 : cur_src; // RULE8
      MUX_PARK: sclk_next = 1'b0;
      default: sclk_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_clk_out <= 1'b0;
    end else begin
      sync_clk_out <= sclk_next;
    end
  end

  // ----------------------------------------------------------------
  // Pulse buffer and resynchronised data
  // ----------------------------------------------------------------
  logic pend_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [FIFO_CNT_W-1:0] fifo_level;
  logic drain;

  // One pulse waits here while the buffer is full; further pulses in that time are dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_in_d_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      sync_in_d_reg <= sync_in;
      if (rise(sync_in, sync_in_d_reg)) begin
        pend_reg <= 1'b1;
      end else if (fifo_in_ready) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // One pulse leaves per rising output clock edge
  assign drain = rise(sclk_next, sync_clk_out);

  pulse_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(FIFO_CNT_W)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(pend_reg),
    .in_data(FIFO_W'(1'b1)),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(drain),
    .level(fifo_level)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resync_data_out <= 1'b0;
    end else if (drain) begin
      resync_data_out <= fifo_out_valid & fifo_out_data[0]; // RULE7
    end
  end

  // ----------------------------------------------------------------
  // Reference output and reference input monitor
  // ----------------------------------------------------------------
  logic [REFCNT_W-1:0] ref_cnt_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_out_a <= 1'b1;
    end else if (ref_en) begin
      ref_out_a <= ref_out_a_src; // RULE11
    end else begin
      ref_out_a <= 1'b1; // RULE10
    end
  end

  // Only rising edges are counted, so the duty cycle plays no part
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_cnt_reg <= '0;
    end else if (rise(filt_reg[IDX_REF], filt_d_reg[IDX_REF])) begin
      ref_cnt_reg <= REFCNT_W'(ref_cnt_reg + 1'b1); // RULE13
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[STAT_READ_BIT] = read_mode;
    status_word[STAT_TEST_BIT] = test_mode;
    status_word[STAT_CLKSEL_BIT] = cur_sel_reg;
    status_word[STAT_SLEEP_BIT] = sleep_active;
    status_word[STAT_FIFO_LSB +: FIFO_CNT_W] = fifo_level;
    status_word[STAT_REFCNT_LSB +: REFCNT_W] = ref_cnt_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        CTRL_ADDR: reg_rdata <= ctrl_reg;
        STATUS_ADDR: reg_rdata <= status_word;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pulse_out_high: assert property (!out_en |=> raw_pulse_out) // RULE1
    else $error("pulse output not high while disabled");
  a_pulse_out_raw: assert property (out_en |=> raw_pulse_out == $past(filt_reg[IDX_DET])) // RULE2
    else $error("pulse output not following detector");
  a_gain_test_hold: assert property (ctrl_reg[1:0] == 2'b11 |=> gain_amp_hold) // RULE3
    else $error("gain not frozen in test mode");
  a_test_osc_src: assert property (test_mode |-> sync_src == filt_reg[IDX_TEST_SYNC]
                                   && ref_out_a_src == filt_reg[IDX_TEST_REF_OUT_A]) // RULE4
    else $error("test oscillator inputs not selected");
  a_sync_ext_only: assert property (in_en |-> sync_in == filt_reg[IDX_EXT]) // RULE5
    else $error("synchroniser not fed from pulse input");
  a_sync_internal: assert property (!out_en |-> sync_in == filt_reg[IDX_DET]) // RULE6
    else $error("detector data not routed internally");
  a_resync_hold: assert property (!drain |=> $stable(resync_data_out)) // RULE7
    else $error("resync data changed off a clock edge");
  a_clk_follow: assert property (mux_state_reg == MUX_RUN && read_mode == cur_sel_reg
                                 |=> sync_clk_out == $past(cur_src)) // RULE8
    else $error("clock output not following selected source");
  a_clk_park_low: assert property (mux_state_reg == MUX_PARK |=> !sync_clk_out) // RULE9
    else $error("clock output high while switching");
  a_ref_idle: assert property (!ref_en |=> ref_out_a) // RULE10
    else $error("reference output active while disabled");
  a_ref_run: assert property (ref_en |=> ref_out_a == $past(ref_out_a_src)) // RULE11
    else $error("reference output not running");
  a_polarity_follow: assert property (##1 comparator_polarity_out == $past(filt_reg[IDX_CMP])) // RULE12
    else $error("polarity output wrong");
  a_sleep_defaults: assert property (sleep_active |=> ctrl_reg == CTRL_RESET ##1 ref_out_a) // RULE15
    else $error("control bits not restored after sleep");

  c_test_mode: cover property (!test_mode ##1 test_mode);
  c_clk_to_sync: cover property (!cur_sel_reg ##1 cur_sel_reg);
  c_fifo_full: cover property (!fifo_in_ready && pend_reg);
  c_ext_route: cover property (in_en && rise(sync_in, sync_in_d_reg));

endmodule : read_data_clock_routing
`default_nettype wire

// file: hw/route_pkg.sv
package route_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_ROUTE_LO_BIT = 0;
  localparam int CTRL_ROUTE_HI_BIT = 1;
  localparam int CTRL_REF_EN_BIT = 5;
  localparam int STAT_READ_BIT = 0;
  localparam int STAT_TEST_BIT = 1;
  localparam int STAT_CLKSEL_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_FIFO_LSB = 8;
  localparam int STAT_REFCNT_LSB = 16;
  localparam int REFCNT_W = 16;

  // ----------------------------------------------------------------
  // Input synchroniser slots
  // ----------------------------------------------------------------
  localparam int NSYNC = 10;
  localparam int IDX_RG = 0;
  localparam int IDX_EXT = 1;
  localparam int IDX_DET = 2;
  localparam int IDX_CMP = 3;
  localparam int IDX_SYNC_CLK = 4;
  localparam int IDX_REF_OUT_A_CLK = 5;
  localparam int IDX_TEST_SYNC = 6;
  localparam int IDX_TEST_REF_OUT_A = 7;
  localparam int IDX_REF = 8;
  localparam int IDX_SLEEP_N = 9;
  localparam logic [NSYNC-1:0] SYNC_RESET = 10'h200;

  // ----------------------------------------------------------------
  // Route decode: three flags per state {test, in_en, out_en}
  // ----------------------------------------------------------------
  localparam logic [11:0] ROUTE_TABLE = 12'hec8;
  localparam int FLAG_OUT = 0;
  localparam int FLAG_IN = 1;
  localparam int FLAG_TEST = 2;

  function automatic logic [2:0] route_decode(input logic [1:0] st);
    route_decode = ROUTE_TABLE[3*int'(st) +: 3];
  endfunction : route_decode

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  // ----------------------------------------------------------------
  // Buffer and clock mux
  // ----------------------------------------------------------------
  localparam int FIFO_W = 1;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_CNT_W = 6;

  typedef enum logic {MUX_RUN, MUX_PARK} mux_state_t;

endpackage : route_pkg

// file: hw/pulse_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 32,
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  // Fill level, head register included
  output logic [CNT_W-1:0] level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic push;
  logic mem_pop;

  // ----------------------------------------------------------------
  // Storage plus a head register, so drain data come from a flop
  // ----------------------------------------------------------------
  assign in_ready = cnt_reg < CNT_W'(DEPTH - 1);
  assign push = in_valid && in_ready;
  assign mem_pop = (cnt_reg != '0) && (!out_valid || out_ready);
  assign level = cnt_reg + CNT_W'(out_valid);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= PTR_W'(wr_ptr_reg + 1'b1);
      end
      if (mem_pop) begin
        rd_ptr_reg <= PTR_W'(rd_ptr_reg + 1'b1);
      end
      cnt_reg <= CNT_W'(cnt_reg + CNT_W'(push) - CNT_W'(mem_pop));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (mem_pop) begin
      out_valid <= 1'b1;
      out_data <= mem_reg[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : pulse_fifo
`default_nettype wire

// file: dv/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Oscillator, tester and reference sources at the far side
// ----------------------------------------------------------------
module osc_model (
  // Enables
  input wire logic run_main,
  input wire logic run_test,
  // Sources
  output logic sync_osc,
  output logic ref_out_a_osc,
  output logic test_sync_osc,
  output logic test_ref_out_a_osc,
  output logic ref_freq
);
  initial begin
    sync_osc = 1'h0;
    ref_out_a_osc = 1'h0;
    test_sync_osc = 1'h0;
    test_ref_out_a_osc = 1'h0;
  end
  // A stopped source stands still low
  always #100 sync_osc = run_main ? ~sync_osc : 1'h0;
  always #150 ref_out_a_osc = run_main ? ~ref_out_a_osc : 1'h0;
  always #125 test_sync_osc = run_test ? ~test_sync_osc : 1'h0;
  always #175 test_ref_out_a_osc = run_test ? ~test_ref_out_a_osc : 1'h0;
  // Uneven duty on purpose, the block must not care
  always begin
    ref_freq = 1'h1;
    #300;
    ref_freq = 1'h0;
    #700;
  end
endmodule : osc_model
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import route_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d, d2;
  logic reg_wr, reg_rd, read_gate_in, sleep_n_in, det_pulse_in, ext_pulse_in, comparator_in;
  logic raw_pulse_out, resync_data_out, comparator_polarity_out, sync_clk_out, ref_out_a;
  logic gain_amp_hold, s_osc, y_osc, ts_osc, ty_osc, ref_freq, run_main, run_test;
  logic [7:0] rnd = 8'h42;
  logic [2:0] fe;
  logic sclk_prev = 1'h0;
  logic seen_data = 1'h0;
  int err_count = 0;
  int n_compared = 0;
  int run_len = 0;
  logic [31:0] c, l0, l1, l2;

  always #12.5 clk = ~clk;

  read_data_clock_routing dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .read_gate_in(read_gate_in), .sleep_n_in(sleep_n_in), .det_pulse_in(det_pulse_in),
    .ext_pulse_in(ext_pulse_in), .raw_pulse_out(raw_pulse_out),
    .resync_data_out(resync_data_out), .comparator_in(comparator_in),
    .comparator_polarity_out(comparator_polarity_out), .sync_osc_in(s_osc),
    .ref_out_a_osc_in(y_osc), .test_sync_osc_in(ts_osc), .test_ref_out_a_osc_in(ty_osc),
    .ref_freq_in(ref_freq), .sync_clk_out(sync_clk_out), .ref_out_a(ref_out_a),
    .gain_amp_hold(gain_amp_hold));

  osc_model partner (.run_main(run_main), .run_test(run_test), .sync_osc(s_osc),
    .ref_out_a_osc(y_osc), .test_sync_osc(ts_osc), .test_ref_out_a_osc(ty_osc), .ref_freq(ref_freq));

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // Flags {test, in_en, out_en} per route state
  function automatic logic [2:0] route_exp(input logic [1:0] st);
    route_exp = (st == 2'h3) ? 3'h7 : {1'h0, st[1], |st};
  endfunction : route_exp

  task automatic fail(input string nm, input string e, input string g);
    err_count++;
    $display("MISMATCH %s expected %s seen %s", nm, e, g);
  endtask : fail

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) fail(nm, $sformatf("%b", e), $sformatf("%b", g));
  endtask : chk_bit

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) fail(nm, $sformatf("%h", e), $sformatf("%h", g));
  endtask : chk_word

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    n_compared++;
    if ($isunknown(g) || g < lo || g > hi) begin
      fail(nm, $sformatf("%0d..%0d", lo, hi), $sformatf("%0d", g));
    end
  endtask : chk_rng

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic level(output logic [31:0] l);
    logic [31:0] s;
    rd(STATUS_ADDR, s);
    l = 32'(s[STAT_FIFO_LSB +: FIFO_CNT_W]);
  endtask : level

  // Wide enough for the input filter to keep it
  task automatic pulse(input logic ext);
    @(posedge clk);
    if (ext) ext_pulse_in <= 1'h1;
    else det_pulse_in <= 1'h1;
    repeat (4) @(posedge clk);
    ext_pulse_in <= 1'h0;
    det_pulse_in <= 1'h0;
    repeat (10) @(posedge clk);
  endtask : pulse

  task automatic edges(input logic sel, input int n, output int cnt);
    logic p;
    logic v;
    cnt = 0;
    p = sel ? ref_out_a : sync_clk_out;
    repeat (n) begin
      @(posedge clk);
      #1;
      v = sel ? ref_out_a : sync_clk_out;
      if (v === 1'h1 && p === 1'h0) cnt++;
      p = v;
    end
  endtask : edges

  // Every run of the clock output lasts at least three cycles
  always @(posedge clk) begin
    if (resync_data_out === 1'h1) seen_data <= 1'h1;
    if (sync_clk_out === sclk_prev) run_len <= run_len + 1;
    else begin
      if (!reset && run_len < 2) fail("sync_clk_out run", ">=3", $sformatf("%0d", run_len + 1));
      run_len <= 0;
    end
    sclk_prev <= sync_clk_out;
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail("timeout", "done", "hung");
    finish_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, read_gate_in} = '0;
    {det_pulse_in, ext_pulse_in, comparator_in, run_main, run_test} = '0;
    sleep_n_in = 1'h1;
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    #1;
    chk_bit("raw_pulse_out", 1'h1, raw_pulse_out);
    chk_bit("ref_out_a", 1'h1, ref_out_a);
    rd(CTRL_ADDR, d);
    chk_word("ctrl", CTRL_RESET, d);
    rd(8'h08, d);
    chk_word("unmapped", 32'h0000_0000, d);
    $display("test 1 done");
    for (int st = 0; st < 4; st++) begin
      fe = route_exp(2'(st));
      wr(CTRL_ADDR, 32'(st));
      repeat (3) begin
        rnd = lfsr(rnd);
        @(posedge clk);
        det_pulse_in <= rnd[0];
        comparator_in <= rnd[1];
        repeat (8) @(posedge clk);
        #1;
        chk_bit("raw_pulse_out", fe[FLAG_OUT] ? rnd[0] : 1'h1, raw_pulse_out);
        chk_bit("polarity", rnd[1], comparator_polarity_out);
        chk_bit("gain_amp_hold", fe[FLAG_TEST], gain_amp_hold);
      end
    end
    @(posedge clk);
    det_pulse_in <= 1'h0;
    $display("test 2 done");
    for (int i = 0; i < 2; i++) begin
      wr(CTRL_ADDR, i ? 32'h0000_0002 : 32'h0000_0000);
      level(l0);
      pulse(1'h0);
      level(l1);
      chk_rng("level det", l0 + 1 - i, l0 + 1 - i, l1);
      pulse(1'h1);
      level(l2);
      chk_rng("level ext", l1 + i, l1 + i, l2);
    end
    wr(CTRL_ADDR, 32'h0000_0000);
    repeat (34) pulse(1'h0);
    level(l0);
    chk_rng("level full", 32, 32, l0);
    run_main <= 1'h1;
    for (int i = 0; i < 100; i++) begin
      level(l0);
      if (l0 == 0) break;
      repeat (10) @(posedge clk);
    end
    chk_rng("level drained", 0, 0, l0);
    chk_bit("resync seen", 1'h1, seen_data);
    $display("test 3 done");
    @(posedge clk);
    read_gate_in <= 1'h1;
    repeat (20) @(posedge clk);
    edges(1'h0, 400, c);
    chk_rng("sclk read", 48, 52, c);
    rd(STATUS_ADDR, d);
    chk_bit("clk select", 1'h1, d[STAT_CLKSEL_BIT]);
    @(posedge clk);
    read_gate_in <= 1'h0;
    repeat (30) @(posedge clk);
    edges(1'h0, 400, c);
    chk_rng("sclk idle", 32, 35, c);
    repeat (6) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      read_gate_in <= ~read_gate_in;
      repeat (10 + int'(rnd[4:0])) @(posedge clk);
    end
    read_gate_in <= 1'h0;
    $display("test 4 done");
    wr(CTRL_ADDR, 32'h0000_0020);
    repeat (20) @(posedge clk);
    edges(1'h1, 400, c);
    chk_rng("ref rate", 32, 35, c);
    wr(CTRL_ADDR, 32'h0000_0000);
    repeat (10) @(posedge clk);
    edges(1'h1, 100, c);
    chk_rng("ref idle", 0, 0, c);
    chk_bit("ref_out_a", 1'h1, ref_out_a);
    wr(CTRL_ADDR, 32'h0000_0020);
    @(posedge clk);
    sleep_n_in <= 1'h0;
    repeat (10) @(posedge clk);
    sleep_n_in <= 1'h1;
    repeat (10) @(posedge clk);
    rd(CTRL_ADDR, d);
    chk_word("ctrl after sleep", CTRL_RESET, d);
    chk_bit("ref after sleep", 1'h1, ref_out_a);
    $display("test 5 done");
    // Main sources stop low first, so entering test mode cuts no clock phase
    run_main <= 1'h0;
    repeat (20) @(posedge clk);
    wr(CTRL_ADDR, 32'h0000_0023);
    run_test <= 1'h1;
    read_gate_in <= 1'h1;
    repeat (30) @(posedge clk);
    edges(1'h0, 420, c);
    chk_rng("sclk test", 40, 44, c);
    edges(1'h1, 420, c);
    chk_rng("ref test", 28, 32, c);
    $display("test 6 done");
    rd(STATUS_ADDR, d);
    chk_bit("test flag", 1'h1, d[STAT_TEST_BIT]);
    chk_bit("read flag", 1'h1, d[STAT_READ_BIT]);
    repeat (400) @(posedge clk);
    rd(STATUS_ADDR, d2);
    chk_rng("ref count", 9, 11, int'(16'(d2[31:16] - d[31:16])));
    $display("test 7 done");
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
